// ==== bench/seq_monitor.sv ====
// Concurrent checks on the stage sequencer ports
`timescale 1ns/1ps
module seq_monitor
	import stage_seq_pkg::*;
(
	// Clock, reset and enable
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         ce,
	// Terminals and command
	input wire logic                         run_in,
	input wire logic                         pause_in,
	input wire stage_seq_pkg::speed_cmd_type speed_cmd
);
	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Idle with a start request and nothing holding it back
	sequence start_req_s;
		ce && speed_cmd.active && run_in && !pause_in && !speed_cmd.run && !speed_cmd.stopped;
	endsequence
	// Two running cycles with a new stage in the second
	sequence stage_move_s;
		speed_cmd.run ##1 speed_cmd.run && $changed(speed_cmd.stage);
	endsequence
	// Pause held over two running cycles
	sequence pause_two_s;
		pause_in && run_in && speed_cmd.run ##1 pause_in && run_in && speed_cmd.run;
	endsequence
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	mode_off_idle_a: assert property (!speed_cmd.active && !$past(speed_cmd.active) |->
		!speed_cmd.run && !speed_cmd.stopped) else $error("run while mode is off");
	run_start_a: assert property (start_req_s |=> speed_cmd.run)
		else $error("run did not start one cycle after request");
	run_drop_a: assert property (ce && !run_in |=> !speed_cmd.run)
		else $error("run kept after terminal released");
	stage_step_a: assert property (stage_move_s |-> speed_cmd.stage == 4'h0 ||
		speed_cmd.stage == $past(speed_cmd.stage) + 4'h1 ||
		speed_cmd.stage == $past(speed_cmd.stage) - 4'h1) else $error("stage jumped");
	end_hold_a: assert property (ce && speed_cmd.stopped && run_in |=> speed_cmd.stopped)
		else $error("stopped state left while run held");
	dir_excl_a: assert property (!(speed_cmd.reverse_direction && speed_cmd.forward_direction))
		else $error("both directions commanded");
	pause_hold_a: assert property (pause_two_s |-> $stable(speed_cmd.stage))
		else $error("stage moved during pause");
	cycle_shown_a: assert property (speed_cmd.run |-> speed_cmd.cycle != 12'h000)
		else $error("cycle number missing while running");
endmodule

bind stage_seq seq_monitor u_mon (.pclk, .presetn, .ce, .run_in, .pause_in, .speed_cmd);

// ==== bench/terminal_model.sv ====
// Input terminal model standing in front of the stage sequencer
`timescale 1ns/1ps
module terminal_model (
	// Clock
	input wire logic pclk,
	// Requests from the bench
	input wire logic run_req,
	input wire logic pause_req,
	// Terminal levels
	output logic     run_in,
	output logic     pause_in
);
	// Quiet terminals at power up
	initial begin
		run_in = 1'b0;
		pause_in = 1'b0;
	end
	// Contacts settle just after an edge, one cycle behind the request
	always @(posedge pclk) begin
		run_in <= run_req;
		pause_in <= pause_req;
	end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the stage sequencer
`timescale 1ns/1ps
`include "stage_seq_cfg.svh"
module testbench;
	import stage_seq_pkg::*;
	typedef struct {logic [31:0] data; logic err;} note_type;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic run_req = 1'b0, pause_req = 1'b0;
	logic pready, pslverr, run_in, pause_in;
	logic [31:0] prdata;
	speed_cmd_type speed_cmd;
	note_type notes[$];
	int err_count = 0, checks_done = 0, visits = 0;
	logic [3:0] last_stage = 4'h0;
	logic [15:0] rnd = 16'h003D;
	// Clock
	always #10 pclk = ~pclk;
	// Short seconds keep the run brief
	stage_seq #(.CLK_HZ(10)) u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .run_in, .pause_in, .speed_cmd);
	terminal_model u_term (.pclk, .run_req, .pause_req, .run_in, .pause_in);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			tally_and_finish;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
		notes.push_back('{e, er});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// ------------------------------------------------------------
	// Watchers
	// ------------------------------------------------------------
	// Read data taken at the rising edge that samples pready high
	always @(posedge pclk) begin
		note_type nt;
		if (psel && penable && pready && !pwrite && notes.size() > 0) begin
			nt = notes.pop_front();
			chk(prdata, nt.data);
			chk(32'(pslverr), 32'(nt.err));
		end
	end
	// Entries into stage 3 tell reciprocating from cyclic order
	always @(negedge pclk) begin
		if (speed_cmd.run && speed_cmd.stage == 4'h3 && last_stage != 4'h3)
			visits++;
		last_stage <= speed_cmd.stage;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int n, ex;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ADDR_MODE, 32'h0, 1'b0);
		rd(`ADDR_CYCLES, 32'h1, 1'b0);
		rd(`ADDR_DUR_FIRST, 32'h1, 1'b0);
		rd(`ADDR_DUR_LAST, 32'h0, 1'b0);
		rd(12'h04C, 32'h0, 1'b1);
		apb(1'b1, `ADDR_MODE, 32'h0000_0007);
		rd(`ADDR_MODE, 32'h0, 1'b0);
		apb(1'b1, `ADDR_CYCLES, 32'h0000_FFFF);
		rd(`ADDR_CYCLES, 32'h0BB8, 1'b0);
		apb(1'b1, `ADDR_CYCLES, 32'h0);
		rd(`ADDR_CYCLES, 32'h1, 1'b0);
		apb(1'b1, `ADDR_DUR_FIRST, 32'h7FFF);
		rd(`ADDR_DUR_FIRST, 32'h7530, 1'b0);
		apb(1'b1, 12'h00C, 32'h8000);
		rd(12'h00C, 32'h8AD0, 1'b0);
		rnd = lfsr(rnd);
		apb(1'b1, 12'h010, {20'h0, rnd[11:0]});
		rd(12'h010, {20'h0, rnd[11:0]}, 1'b0);
		// Master 1 s, stage 3 reverse 1 s, other stages skipped, two cycles
		apb(1'b1, `ADDR_DUR_FIRST, 32'h1);
		apb(1'b1, 12'h00C, 32'h0);
		apb(1'b1, 12'h010, 32'h0);
		apb(1'b1, 12'h014, 32'hFFFF);
		apb(1'b1, `ADDR_CYCLES, 32'h2);
		for (int m = 1; m <= 4; m++) begin
			apb(1'b1, `ADDR_MODE, 32'(m));
			ex = (m % 2 == 1) ? 4 : 2;
			visits = 0;
			run_req <= 1'b1;
			n = 0;
			while (visits < 1 && n < 2000) begin
				@(posedge pclk);
				n++;
			end
			pause_req <= 1'b1;
			repeat (20) @(posedge pclk);
			rd(`ADDR_STATUS, 32'h0001_00D3, 1'b0);
			chk(32'(speed_cmd.reverse_direction), 32'h1);
			pause_req <= 1'b0;
			while (visits < ex && n < 2000) begin
				@(posedge pclk);
				n++;
			end
			if (n >= 2000) begin
				err_count++;
				tally_and_finish;
			end
			repeat (80) @(posedge pclk);
			chk(32'(visits), 32'(ex));
			chk(32'(speed_cmd.stopped), 32'(m <= 2));
			chk(32'(speed_cmd.run), 32'(m > 2));
			if (m > 2)
				chk({speed_cmd.stage, speed_cmd.forward_direction}, 32'h1);
			run_req <= 1'b0;
			repeat (3) @(posedge pclk);
		end
		apb(1'b1, `ADDR_MODE, 32'h0);
		run_req <= 1'b1;
		repeat (5) @(posedge pclk);
		chk({speed_cmd.active, speed_cmd.run}, 32'h0);
		run_req <= 1'b0;
		tally_and_finish;
	end
endmodule

// ==== hdl/seconds_tick.sv ====
// One-second tick generator for the stage timer
`timescale 1ns/1ps
module seconds_tick #(
	parameter int TICK_CYCLES = 50_000_000
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Control
	input  wire logic restart,
	input  wire logic run,
	// Tick out
	output logic      tick
);
	localparam int W = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic [W-1:0] count;
	} tick_state_type;

	tick_state_type r;
	tick_state_type n;

	if (TICK_CYCLES < 2) begin : g_check
		$error("seconds_tick: TICK_CYCLES must be at least 2");
	end

	// Counter holds while not running, so a pause keeps the partial second
	always_comb begin
		n = r;
		if (restart) begin
			n.count = '0;
		end else if (run) begin
			if (r.count == W'(TICK_CYCLES - 1)) begin
				n.count = '0;
			end else begin
				n.count = r.count + W'(1);
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	// Tick is gated by run, so a pause arriving on the last count leaves no stale pulse
	assign tick = run & ~restart & (r.count == W'(TICK_CYCLES - 1));
endmodule

// ==== hdl/stage_seq.sv ====
// Automatic multi-stage speed sequencer with APB register access
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "stage_seq_cfg.svh"

// Operation
// RULE_01: Mode zero keeps the sequencer idle and leaves speed to the normal sources.
// RULE_02: Mode 1 runs master, stages 1-15, then 15 back to master (32 steps), then stops.
// RULE_03: Mode 2 runs master, stages 1-15 and wraps (16 steps), stopping after the cycles.
// RULE_04: Mode 3 sequences like mode 1 but then keeps running at master speed.
// RULE_05: Mode 4 sequences like mode 2 but then keeps running at master speed.
// RULE_06: The cycle count ranges 1 to 3000, defaults to 1, and sets cycles before the end.
// RULE_07: The master duration is signed seconds, -30000 to 30000, reset value 1.
// RULE_08: Fifteen stage durations are signed seconds, -30000 to 30000, reset value 0.
// RULE_09: In modes 1-4 the run and pause inputs govern and override other speed sources.
// RULE_10: The current cycle number and stage index are presented while sequencing.
// RULE_11: A negative duration runs reverse, a positive one forward, magnitude as time.
// RULE_12: A stage with zero duration is skipped straight to the next step.
// RULE_13: The stage timer counts the magnitude in one-second ticks, then advances.
// RULE_14: Pause freezes timer and step, and release resumes from the frozen value.
module stage_seq
	import stage_seq_pkg::*;
#(
	parameter int CLK_HZ = 50_000_000
) (
	// Clock, reset and enable
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  ce,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// Input terminals
	input  wire logic                  run_in,
	input  wire logic                  pause_in,
	// Speed command path
	output stage_seq_pkg::speed_cmd_type speed_cmd
);
	import stage_seq_pkg::*;

	// ---------------------------------------------------------------
	// Timing constants
	// ---------------------------------------------------------------
	localparam int TICK_CYCLES = `ONE_SECOND_S * CLK_HZ;

	if (CLK_HZ < 2) begin : g_check
		$error("stage_seq: CLK_HZ must be at least 2");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	seq_regs_type r;
	seq_regs_type n;

	logic        tick;
	logic        tick_run;
	logic        tick_restart;
	logic        setup;
	logic        access;
	logic        dur_hit;
	logic        mapped;
	logic [11:0] dur_off;
	logic [3:0]  dur_idx;
	logic        mode_on;
	logic        recip;
	logic        master_end;
	logic [4:0]  last_step;
	logic [3:0]  cur_stage;
	logic [15:0] cur_dur;
	logic [14:0] cur_mag;
	logic        advance;
	logic [31:0] status_word;

	// Position in the sequence to stage index; back half counts down
	function automatic logic [3:0] stage_of(input logic [4:0] s);
		if (s[4]) begin
			stage_of = 4'(`RECIP_LAST - s);
		end else begin
			stage_of = s[3:0];
		end
	endfunction

	// Clamp a signed duration into its legal range
	function automatic logic [15:0] clamp_dur(input logic [15:0] v);
		if ($signed(v) > $signed(`DUR_MAX)) begin
			clamp_dur = `DUR_MAX;
		end else if ($signed(v) < $signed(`DUR_MIN)) begin
			clamp_dur = `DUR_MIN;
		end else begin
			clamp_dur = v;
		end
	endfunction

	// Clamp the cycle count into its legal range
	function automatic logic [15:0] clamp_cycles(input logic [15:0] v);
		if (v < `CYCLES_MIN) begin
			clamp_cycles = `CYCLES_MIN;
		end else if (v > `CYCLES_MAX) begin
			clamp_cycles = `CYCLES_MAX;
		end else begin
			clamp_cycles = v;
		end
	endfunction

	// ---------------------------------------------------------------
	// Address decode and sequence helpers
	// ---------------------------------------------------------------
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign dur_off = paddr - `ADDR_DUR_FIRST;
	assign dur_idx = dur_off[5:2];
	assign dur_hit = (paddr >= `ADDR_DUR_FIRST) && (paddr <= `ADDR_DUR_LAST)
		&& (paddr[1:0] == 2'h0);
	assign mapped  = (paddr == `ADDR_MODE) || (paddr == `ADDR_CYCLES)
		|| (paddr == `ADDR_STATUS) || dur_hit;

	// Handshake answers at once; a frozen block holds the master off
	assign pready  = ce;
	assign pslverr = access & ~mapped;
	assign prdata  = r.rdata;

	assign mode_on    = (r.mode != `MODE_OFF); // [RULE_01]
	assign recip      = (r.mode == `MODE_RECIP_STOP) || (r.mode == `MODE_RECIP_MASTER);
	assign master_end = (r.mode == `MODE_RECIP_MASTER) || (r.mode == `MODE_CYCLIC_MASTER);
	assign last_step  = recip ? `RECIP_LAST : `CYCLIC_LAST; // [RULE_02] [RULE_03]
	assign cur_stage  = stage_of(r.step);
	assign cur_dur    = r.dur[cur_stage];
	// Sign picks direction, magnitude is the time
	assign cur_mag    = cur_dur[15] ? 15'(16'h0000 - cur_dur) : cur_dur[14:0]; // [RULE_11]

	// Tick counter runs only while timing and not paused
	assign tick_run     = (r.state == SEQ_TIMING) & ~pause_in; // [RULE_14]
	assign tick_restart = (r.state != SEQ_TIMING);

	// Status word for software
	always_comb begin
		status_word = '0;
		status_word[`ST_STAGE_LSB +: 4]  = cur_stage;
		status_word[`ST_RUN_BIT]         = speed_cmd.run;
		status_word[`ST_DONE_BIT]        = (r.state == SEQ_STOPPED)
			|| (r.state == SEQ_HOLD_MASTER);
		status_word[`ST_REV_BIT]         = r.reverse;
		status_word[`ST_PAUSE_BIT]       = pause_in & mode_on;
		status_word[`ST_CYCLE_LSB +: 12] = r.cycle;
	end

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		n = r;
		advance = 1'b0;

		// Read data is captured in the setup phase so it leaves a flop
		if (setup && !pwrite) begin
			if (paddr == `ADDR_MODE) begin
				n.rdata = {29'h0, r.mode};
			end else if (paddr == `ADDR_CYCLES) begin
				n.rdata = {16'h0, r.cycles};
			end else if (dur_hit) begin
				n.rdata = {16'h0, r.dur[dur_idx]};
			end else if (paddr == `ADDR_STATUS) begin
				n.rdata = status_word; // [RULE_10]
			end else begin
				n.rdata = 32'h0;
			end
		end

		// Writes take effect at the access edge; out-of-range cycles and durations clamp, an out-of-range mode is ignored
		if (access && pwrite) begin
			if (paddr == `ADDR_MODE) begin
				if (pwdata[2:0] <= `MODE_CYCLIC_MASTER) begin
					n.mode = pwdata[2:0];
				end
			end else if (paddr == `ADDR_CYCLES) begin
				n.cycles = clamp_cycles(pwdata[15:0]); // [RULE_06]
			end else if (dur_hit) begin
				n.dur[dur_idx] = clamp_dur(pwdata[15:0]); // [RULE_07] [RULE_08]
			end
		end

		// Sequencer; a dropped run input is a stop command in any state
		case (r.state)
			SEQ_IDLE: begin
				if (mode_on && run_in) begin // [RULE_09]
					n.step  = 5'h00;
					n.cycle = 12'h001;
					n.state = SEQ_LOAD;
				end
			end
			SEQ_LOAD: begin
				if (!pause_in) begin
					if (cur_dur == 16'h0000) begin
						advance = 1'b1; // [RULE_12]
					end else begin
						n.remain  = cur_mag; // [RULE_13]
						n.reverse = cur_dur[15]; // [RULE_11]
						n.state   = SEQ_TIMING;
					end
				end
			end
			SEQ_TIMING: begin
				// Tick never arrives while paused, so the count holds
				if (tick) begin
					if (r.remain == 15'h0001) begin
						advance = 1'b1; // [RULE_13]
					end else begin
						n.remain = r.remain - 15'h0001;
					end
				end
			end
			SEQ_HOLD_MASTER: begin
				n.step    = 5'h00;
				n.reverse = r.dur[0][15];
			end
			SEQ_STOPPED: begin
				n.step = r.step;
			end
			default: begin
				n.state = SEQ_IDLE;
			end
		endcase

		// Move to the next step, next cycle, or the end action
		if (advance) begin
			if (r.step == last_step) begin // [RULE_02] [RULE_03]
				if (r.cycle >= r.cycles[11:0]) begin // [RULE_06]
					n.step = 5'h00;
					if (master_end) begin
						n.reverse = r.dur[0][15];
						n.state   = SEQ_HOLD_MASTER; // [RULE_04] [RULE_05]
					end else begin
						n.state = SEQ_STOPPED; // [RULE_02] [RULE_03]
					end
				end else begin
					n.cycle = r.cycle + 12'h001;
					n.step  = 5'h00;
					n.state = SEQ_LOAD;
				end
			end else begin
				n.step  = r.step + 5'h01;
				n.state = SEQ_LOAD;
			end
		end

		// Mode zero or a stop command returns to idle
		if (!mode_on || !run_in) begin // [RULE_01] [RULE_09]
			n.state   = SEQ_IDLE;
			n.step    = 5'h00;
			n.cycle   = 12'h000;
			n.remain  = 15'h0000;
			n.reverse = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.state   <= SEQ_IDLE;
			r.mode    <= `MODE_OFF;
			r.cycles  <= `CYCLES_RESET;
			r.dur     <= {{15{`STAGE_DUR_RESET}}, `MASTER_DUR_RESET};
			r.step    <= 5'h00;
			r.cycle   <= 12'h000;
			r.remain  <= 15'h0000;
			r.reverse <= 1'b0;
			r.rdata   <= 32'h0;
		end else if (ce) begin
			r <= n;
		end
	end

	// ---------------------------------------------------------------
	// One-second tick
	// ---------------------------------------------------------------
	seconds_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.pclk   (pclk),
		.presetn(presetn),
		.ce     (ce),
		.restart(tick_restart),
		.run    (tick_run),
		.tick   (tick)
	);

	// ---------------------------------------------------------------
	// Speed command outputs
	// ---------------------------------------------------------------
	// Sequencer owns the speed command whenever a mode is enabled
	always_comb begin
		speed_cmd.active  = mode_on; // [RULE_09]
		speed_cmd.run     = (r.state == SEQ_LOAD) || (r.state == SEQ_TIMING)
			|| (r.state == SEQ_HOLD_MASTER);
		speed_cmd.stopped = (r.state == SEQ_STOPPED);
		speed_cmd.reverse_direction = speed_cmd.run & r.reverse; // [RULE_11]
		speed_cmd.forward_direction = speed_cmd.run & ~r.reverse;
		speed_cmd.stage   = cur_stage; // [RULE_10]
		speed_cmd.cycle   = r.cycle;
	end
endmodule

// ==== hdl/stage_seq_cfg.svh ====
// Register map, reset values, limits and timing constants of the stage sequencer
`ifndef STAGE_SEQ_CFG_SVH
`define STAGE_SEQ_CFG_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define ADDR_MODE       12'h000
`define ADDR_CYCLES     12'h004
`define ADDR_DUR_FIRST  12'h008
`define ADDR_DUR_LAST   12'h044
`define ADDR_STATUS     12'h048

// ---------------------------------------------------------------
// Sequence modes
// ---------------------------------------------------------------
`define MODE_OFF           3'h0
`define MODE_RECIP_STOP    3'h1
`define MODE_CYCLIC_STOP   3'h2
`define MODE_RECIP_MASTER  3'h3
`define MODE_CYCLIC_MASTER 3'h4

// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define CYCLES_RESET     16'h0001
`define CYCLES_MIN       16'h0001
`define CYCLES_MAX       16'h0BB8
`define MASTER_DUR_RESET 16'h0001
`define STAGE_DUR_RESET  16'h0000
`define DUR_MAX          16'h7530
`define DUR_MIN          16'h8AD0

// ---------------------------------------------------------------
// Step positions and status fields
// ---------------------------------------------------------------
`define RECIP_LAST    5'h1F
`define CYCLIC_LAST   5'h0F
`define ST_STAGE_LSB  0
`define ST_RUN_BIT    4
`define ST_DONE_BIT   5
`define ST_REV_BIT    6
`define ST_PAUSE_BIT  7
`define ST_CYCLE_LSB  16

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ONE_SECOND_S  1

`endif

// ==== hdl/stage_seq_pkg.sv ====
// Types shared by the stage sequencer files
package stage_seq_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_LOAD,
		SEQ_TIMING,
		SEQ_HOLD_MASTER,
		SEQ_STOPPED
	} seq_state_type;

	// Speed and direction command toward the drive
	typedef struct packed {
		logic        active;
		logic        run;
		logic        stopped;
		logic        reverse_direction;
		logic        forward_direction;
		logic [3:0]  stage;
		logic [11:0] cycle;
	} speed_cmd_type;

	// Whole state of the sequencer
	typedef struct packed {
		seq_state_type    state;
		logic [2:0]       mode;
		logic [15:0]      cycles;
		logic [15:0][15:0] dur;
		logic [4:0]       step;
		logic [11:0]      cycle;
		logic [14:0]      remain;
		logic             reverse;
		logic [31:0]      rdata;
	} seq_regs_type;

endpackage
